/* pll_register_bank.sv */
/*
  Front register bank of a clock synthesizer behind a 3-wire host port,
  with forwarding of the indirect word to the VCO subsystem.
  Assumes host pins are asynchronous to ref_clk and at least 4x slower.
*/
// Operation
// - Indirect word: id[2:0], addr[6:3], data[15:7]
// - Calibration rewrites only the data field
// - Each indirect write starts a forward
// - Indirect read returns last forwarded word
// - Manual reset word layout: tune, caps, select
// - Location zero reads fixed identity word
// - Location zero write sets read address
// - Bit five soft-resets the serial port
// - Reference divider 14 bits, resets to one
// - Integer divide 19 bits, resets to 25
// - Fractional divide 24 bits, resets zero
// - Control word ten bits, resets 002h
// - Link clock is reference over eight
// - Forwarded word goes MSB first
// - Frame: data, address, chip; commit on enable rise
`timescale 1ns/1ps
module pll_register_bank
  import pll_bank_pkg::*;
#(
  parameter logic [23:0] IDENTITY = 24'h5A0C31  // Arbitrary identity value
) (
  // Clock and reset
  input  wire logic                ref_clk,
  input  wire logic                rst_n,
  // Host serial port
  input  wire logic                sclk,
  input  wire logic                sdi,
  input  wire logic                serialEnable,
  output logic                     sdo,
  // Automatic calibration engine
  input  wire logic                calValid,
  input  wire logic [8:0]          calData,
  input  wire logic                refBufferEnable,
  // Register contents to the synthesizer core
  output logic [CTRL_W-1:0]        ctrlWord,
  output logic [REFDIV_W-1:0]      refDivider,
  output logic [INT_W-1:0]         intDivide,
  output logic [FRAC_W-1:0]        fracDivide,
  output logic                     refDividerActive,
  // Internal VCO serial link
  output logic                     linkClk,
  output logic                     linkData,
  output logic                     linkEnable,
  output logic                     linkBusy
);
  // ****************************************
  // Declarations
  // ****************************************
  logic [2:0]        sclkSync;     // Two stages plus edge history
  logic [2:0]        senSync;
  logic [1:0]        sdiSync;
  logic              sclkRise;
  logic              senRise;
  logic              senFall;
  logic [31:0]       frameReg;     // Incoming frame, MSB first
  logic [5:0]        bitCnt;       // Host bits seen this frame
  logic [23:0]       sdoShift;     // Read data going out
  logic [4:0]        readAddr_reg; // Open-mode read address
  logic [CTRL_W-1:0] ctrl_reg;
  logic [REFDIV_W-1:0] refDiv_reg;
  logic [INT_W-1:0]  int_reg;
  logic [FRAC_W-1:0] frac_reg;
  logic [VCO_W-1:0]  vco_reg;      // Staging copy of the indirect word
  logic              send_reg;     // Forward request pulse
  logic [23:0]       wrData;
  logic [4:0]        wrAddr;
  logic              wrEn;
  logic              softRst;
  logic              hostVcoWr;
  logic              calWr;
  logic [23:0]       readWord;

  vco_link_if lnkBus ();

  // ****************************************
  // Host pin synchronisers and edges
  // ****************************************
  // Pins are asynchronous; only the second stage onward is read
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclkSync <= 3'h0;
      senSync  <= 3'h7;
      sdiSync  <= 2'h0;
    end else begin
      sclkSync <= {sclkSync[1:0], sclk};
      senSync  <= {senSync[1:0], serialEnable};
      sdiSync  <= {sdiSync[0], sdi};
    end
  end

  assign sclkRise = sclkSync[1] && !sclkSync[2];
  assign senRise  = senSync[1] && !senSync[2];
  assign senFall  = !senSync[1] && senSync[2];

  // ****************************************
  // Frame decode
  // ****************************************
  assign wrData    = frameReg[31:8];
  assign wrAddr    = frameReg[7:3];
  // Only a full frame to our chip address is committed
  assign wrEn      = senRise && (bitCnt == FRAME_BITS) &&
                     (frameReg[2:0] == CHIP_ADDR);
  assign softRst   = wrEn && (wrAddr == ADDR_ID) && wrData[SOFT_RST_BIT];
  assign hostVcoWr = wrEn && (wrAddr == ADDR_VCO) && !softRst;
  assign calWr     = calValid && !hostVcoWr;  // Host write takes priority

  // Readback selection
  assign readWord =
      (readAddr_reg == ADDR_ID)     ? IDENTITY :
      (readAddr_reg == ADDR_CTRL)   ? 24'(ctrl_reg) :
      (readAddr_reg == ADDR_REFDIV) ? 24'(refDiv_reg) :
      (readAddr_reg == ADDR_INT)    ? 24'(int_reg) :
      (readAddr_reg == ADDR_FRAC)   ? frac_reg :
      (readAddr_reg == ADDR_VCO)    ? 24'(lnkBus.sentWord) :
                                      24'h000000;

  // ****************************************
  // Host shift logic
  // ****************************************
  // Frame start reloads readback; soft reset also clears the count
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      frameReg <= 32'h00000000;
      bitCnt   <= 6'h00;
      sdoShift <= 24'h000000;
    end else if (softRst) begin
      bitCnt   <= 6'h00;
    end else if (senFall) begin
      bitCnt   <= 6'h00;
      sdoShift <= readWord;
    end else if (sclkRise && !senSync[1]) begin
      frameReg <= {frameReg[30:0], sdiSync[1]};
      sdoShift <= {sdoShift[22:0], 1'b0};
      if (bitCnt != FRAME_BITS) bitCnt <= bitCnt + 6'h01;
    end
  end

  // Read data out from a flop, MSB first
  assign sdo = sdoShift[23];

  // ****************************************
  // Register file
  // ****************************************
  // Soft reset restores every default; identity is a constant
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      readAddr_reg <= 5'h00;
      ctrl_reg     <= CTRL_RESET;
      refDiv_reg   <= REFDIV_RESET;
      int_reg      <= INT_RESET;
      frac_reg     <= FRAC_RESET;
    end else if (softRst) begin
      readAddr_reg <= 5'h00;
      ctrl_reg     <= CTRL_RESET;
      refDiv_reg   <= REFDIV_RESET;
      int_reg      <= INT_RESET;
      frac_reg     <= FRAC_RESET;
    end else if (wrEn) begin
      case (wrAddr)
        ADDR_ID:     readAddr_reg <= wrData[RDADDR_MSB:0];
        ADDR_CTRL:   ctrl_reg     <= wrData[CTRL_W-1:0];
        ADDR_REFDIV: refDiv_reg   <= wrData[REFDIV_W-1:0];
        ADDR_INT:    int_reg      <= wrData[INT_W-1:0];
        ADDR_FRAC:   frac_reg     <= wrData[FRAC_W-1:0];
        default: ;  // Indirect word handled below; others unmapped
      endcase
    end
  end

  // ****************************************
  // Indirect word and forward request
  // ****************************************
  // Calibration keeps id and address, so the host must park them
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      vco_reg  <= VCO_RESET;
      send_reg <= 1'b0;
    end else if (softRst) begin
      vco_reg  <= VCO_RESET;
      send_reg <= 1'b0;
    end else if (hostVcoWr) begin
      vco_reg  <= wrData[VCO_W-1:0];
      send_reg <= 1'b1;
    end else if (calWr) begin
      vco_reg[VCO_W-1:SUB_DAT_LSB] <= calData;
      send_reg <= 1'b1;
    end else begin
      send_reg <= 1'b0;
    end
  end

  assign lnkBus.reqValid = send_reg;
  assign lnkBus.reqWord  = vco_reg;

  // ****************************************
  // Outputs to the core
  // ****************************************
  assign ctrlWord         = ctrl_reg;
  assign refDivider       = refDiv_reg;
  assign intDivide        = int_reg;
  assign fracDivide       = frac_reg;
  // Divider only counts with the reference buffer on
  assign refDividerActive = refBufferEnable && (refDiv_reg != 14'h0000);
  assign linkBusy         = lnkBus.busy;

  // Link sequencer at reference over four
  vco_serial_link #(
    .DIV (FSM_DIV)
  ) u_link (
    .ref_clk    (ref_clk),
    .rst_n      (rst_n),
    .lnk        (lnkBus),
    .linkClk    (linkClk),
    .linkData   (linkData),
    .linkEnable (linkEnable)
  );

  // ****************************************
  // Checks
  // ****************************************
  a_cal_fields_kept: assert property (@(posedge ref_clk) disable iff (!rst_n)
    calWr && !softRst |=> vco_reg[SUB_RA_MSB:0] == $past(vco_reg[SUB_RA_MSB:0])
    && vco_reg[VCO_W-1:SUB_DAT_LSB] == $past(calData) && send_reg)
    else $error("Calibration touched id or address");
  a_read_addr: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wrEn && wrAddr == ADDR_ID && !softRst |=> readAddr_reg == $past(wrData[4:0]))
    else $error("Read address not stored");
  a_soft_defaults: assert property (@(posedge ref_clk) disable iff (!rst_n)
    softRst |=> ctrl_reg == 10'h002 && refDiv_reg == 14'h0001
    && int_reg == 19'h00019 && frac_reg == 24'h000000 && vco_reg == 16'h0000)
    else $error("Soft reset left a register changed");
  a_id_readback: assert property (@(posedge ref_clk) disable iff (!rst_n)
    senFall && readAddr_reg == ADDR_ID && !softRst |=> sdoShift == IDENTITY)
    else $error("Identity word not presented");
  a_refdiv_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wrEn && wrAddr == ADDR_REFDIV && !softRst |=> refDiv_reg == $past(wrData[13:0]))
    else $error("Reference divider write lost");
  a_int_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wrEn && wrAddr == ADDR_INT && !softRst |=> int_reg == $past(wrData[18:0]))
    else $error("Integer divide write lost");
  a_vco_forward: assert property (@(posedge ref_clk) disable iff (!rst_n)
    hostVcoWr |=> send_reg && vco_reg == $past(wrData[15:0]))
    else $error("Indirect write not forwarded");
  a_frame_commit: assert property (@(posedge ref_clk) disable iff (!rst_n)
    senRise && bitCnt != FRAME_BITS |-> !wrEn)
    else $error("Short frame committed");
  c_host_vco: cover property (@(posedge ref_clk) disable iff (!rst_n) hostVcoWr);
  c_cal_update: cover property (@(posedge ref_clk) disable iff (!rst_n) calWr);
  c_soft_reset: cover property (@(posedge ref_clk) disable iff (!rst_n) softRst);
endmodule

/* pll_bank_pkg.sv */
/*
  Constants for the synthesizer front register bank: locations, field
  positions, reset values, serial frame layout and link timing.
  Assumes a single 25 MHz block clock that also stands for the reference.
*/
package pll_bank_pkg;
  // ****************************************
  // Register locations
  // ****************************************
  localparam logic [4:0]  ADDR_ID     = 5'h00;  // Identity (read) / read address (write)
  localparam logic [4:0]  ADDR_CTRL   = 5'h01;  // Reserved control word
  localparam logic [4:0]  ADDR_REFDIV = 5'h02;  // Reference divider
  localparam logic [4:0]  ADDR_INT    = 5'h03;  // Integer divide
  localparam logic [4:0]  ADDR_FRAC   = 5'h04;  // Fractional divide
  localparam logic [4:0]  ADDR_VCO    = 5'h05;  // Indirect subsystem access

  // ****************************************
  // Field positions and widths
  // ****************************************
  localparam int          RDADDR_MSB  = 4;      // Read address field top bit
  localparam int          SOFT_RST_BIT = 5;     // Soft reset strobe bit
  localparam int          CTRL_W      = 10;
  localparam int          REFDIV_W    = 14;
  localparam int          INT_W       = 19;
  localparam int          FRAC_W      = 24;
  localparam int          DATA_W      = 24;     // Host frame data bits
  localparam int          VCO_W       = 16;     // Indirect word width
  localparam int          SUB_ID_MSB  = 2;      // subsystem_id_field [2:0]
  localparam int          SUB_RA_MSB  = 6;      // subsystem_reg_addr_field [6:3]
  localparam int          SUB_DAT_LSB = 7;      // subsystem_data_field [15:7]
  localparam int          SUB_DAT_W   = 9;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [9:0]  CTRL_RESET   = 10'h002;
  localparam logic [13:0] REFDIV_RESET = 14'h0001;
  localparam logic [18:0] INT_RESET    = 19'h00019;
  localparam logic [23:0] FRAC_RESET   = 24'h000000;
  localparam logic [15:0] VCO_RESET    = 16'h0000;

  // ****************************************
  // Host frame and link timing
  // ****************************************
  localparam logic [5:0]  FRAME_BITS  = 6'h20;  // 24 data + 5 address + 3 chip
  localparam logic [2:0]  CHIP_ADDR   = 3'h0;   // Chip address this device answers
  localparam int          REF_CLK_HZ  = 25_000_000;
  localparam int          FSM_MAX_HZ  = 50_000_000; // Link clock ceiling
  localparam int          FSM_DIV     = 4;      // Default reference divide for link

  // Link sequencer states
  typedef enum logic [0:0] {
    LINK_IDLE  = 1'b0,
    LINK_SHIFT = 1'b1
  } link_state_e;
endpackage

/* vco_link_if.sv */
/*
  Carrier between the register bank and the subsystem link sequencer.
  Assumes both ends sit on the same block clock.
*/
`timescale 1ns/1ps
interface vco_link_if;
  logic        reqValid;  // One-cycle request to forward reqWord
  logic [15:0] reqWord;   // Word to forward
  logic        busy;      // Link shifting or a word pending
  logic [15:0] sentWord;  // Word most recently sent

  modport bank (output reqValid, output reqWord, input busy, input sentWord);
  modport link (input reqValid, input reqWord, output busy, output sentWord);
endinterface

/* vco_serial_link.sv */
/*
  Internal serial link sequencer: shifts 16-bit words to the VCO subsystem.
  Assumes requests arrive from logic on the same clock.
*/
`timescale 1ns/1ps
module vco_serial_link
  import pll_bank_pkg::*;
#(
  parameter int DIV = FSM_DIV  // Block clock cycles per link tick
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  // Bank side
  vco_link_if.link  lnk,
  // Link pins
  output logic      linkClk,
  output logic      linkData,
  output logic      linkEnable
);
  // Link rate must stay under the ceiling; the tick divider is only 8 bits
  if (DIV < 1 || DIV > 256 || REF_CLK_HZ / DIV > FSM_MAX_HZ) begin : g_chk
    $error("Link divide gives a rate above the ceiling");
  end

  localparam int START_MAX = DIV + 1;  // Worst wait from request to enable

  logic [7:0]  divCnt;     // Tick divider
  logic        tick;       // One-cycle link clock enable
  link_state_e state;      // Sequencer state
  logic        pendValid;  // Held word waiting for the link
  logic [15:0] pendWord;
  logic [15:0] shiftReg;   // Outgoing word, MSB at the top
  logic [4:0]  bitCnt;     // Bits left
  logic        phase;      // 0: data set up, 1: clock high
  logic        startXfer;
  logic        lastBit;

  assign tick      = (divCnt == 8'(DIV - 1));
  assign startXfer = tick && (state == LINK_IDLE) && pendValid;
  assign lastBit   = (bitCnt == 5'h01);
  assign lnk.busy  = (state != LINK_IDLE) || pendValid;
  assign linkData  = shiftReg[VCO_W-1];
  assign linkEnable = (state == LINK_SHIFT);

  // ****************************************
  // Divider for the slower link rate
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) divCnt <= 8'h00;
    else if (tick) divCnt <= 8'h00;
    else divCnt <= divCnt + 8'h01;
  end

  // ****************************************
  // Pending slot: a new word waits while the link is busy
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pendValid <= 1'b0;
      pendWord  <= VCO_RESET;
    end else if (lnk.reqValid) begin
      // A request in the start cycle wins, so it is never lost
      pendValid <= 1'b1;
      pendWord  <= lnk.reqWord;
    end else if (startXfer) begin
      pendValid <= 1'b0;
    end
  end

  // ****************************************
  // Shift sequencer, two ticks per bit
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state        <= LINK_IDLE;
      shiftReg     <= VCO_RESET;
      bitCnt       <= 5'h00;
      phase        <= 1'b0;
      linkClk      <= 1'b0;
      lnk.sentWord <= VCO_RESET;
    end else if (tick) begin
      case (state)
        LINK_IDLE: begin
          if (pendValid) begin
            state        <= LINK_SHIFT;
            shiftReg     <= pendWord;
            lnk.sentWord <= pendWord;
            bitCnt       <= 5'(VCO_W);
            phase        <= 1'b0;
          end
        end
        LINK_SHIFT: begin
          phase   <= ~phase;
          linkClk <= ~phase;  // Subsystem samples on the rising link clock
          if (phase) begin
            shiftReg <= {shiftReg[VCO_W-2:0], 1'b0};
            bitCnt   <= bitCnt - 5'h01;
            if (lastBit) state <= LINK_IDLE;
          end
        end
        default: state <= LINK_IDLE;
      endcase
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_start_latency: assert property (@(posedge ref_clk) disable iff (!rst_n)
    lnk.reqValid && !lnk.busy |-> ##[1:START_MAX] linkEnable)
    else $error("Forwarded word did not start");
  a_msb_first: assert property (@(posedge ref_clk) disable iff (!rst_n)
    startXfer |=> linkData == $past(pendWord[VCO_W-1]))
    else $error("First link bit is not the MSB");
  a_pending_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    lnk.reqValid && linkEnable |=> pendValid && pendWord == $past(lnk.reqWord))
    else $error("Word sent while link busy was dropped");
  a_sent_word: assert property (@(posedge ref_clk) disable iff (!rst_n)
    startXfer |=> lnk.sentWord == $past(pendWord))
    else $error("Readback does not show the word sent");
  c_back_to_back: cover property (@(posedge ref_clk) disable iff (!rst_n)
    lnk.reqValid && linkEnable);
  c_full_word: cover property (@(posedge ref_clk) disable iff (!rst_n)
    $fell(linkEnable));
endmodule

/* host_port_model.sv */
/*
  Host controller model that drives the 3-wire serial programming port.
  Assumes ref_clk runs at 25 MHz; sclk runs at 320 ns only inside frames.
*/
`timescale 1ns/1ps
module host_port_model (
  // Clock
  input  wire logic ref_clk,
  // Serial port pins
  output logic      sclk,
  output logic      sdi,
  output logic      serialEnable,
  input  wire logic sdo
);
  // ****************************************
  // Frame engine
  // ****************************************
  // Idle pins: clock parked low, frame enable high
  initial begin
    sclk = 1'b0;
    sdi = 1'b0;
    serialEnable = 1'b1;
  end

  // Wait n cycles; every pin change lands on a falling edge
  task automatic waitn(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // One frame of nBits clock rises; readback is sampled before each of the first 24 rises
  task automatic frame(input logic [23:0] d, input logic [4:0] a,
                       input logic [2:0] chip, input int nBits,
                       output logic [23:0] rd);
    logic [31:0] bits;
    bits = {d, a, chip};
    rd = 24'h000000;
    waitn(1);
    serialEnable = 1'b0;
    for (int i = 0; i < nBits; i++) begin
      sdi = bits[31 - i];
      waitn(4);
      if (i < 24) rd[23 - i] = sdo;
      sclk = 1'b1;
      waitn(4);
      sclk = 1'b0;
    end
    waitn(4);
    serialEnable = 1'b1;
    // Released data line flips so a stale bit is never mistaken for data
    sdi = ~sdi;
    waitn(8);
  endtask
endmodule

/* pll_register_bank_tb.sv */
/*
  Self-checking bench for the synthesizer front register bank.
  Assumes the host model beside it and the design's default link divide.
*/
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
  begin \
    total_checks++; \
    if ((got) !== (ex)) begin \
      failures++; \
      $display("Error %s expected %0h seen %0h", nm, ex, got); \
    end \
  end
module pll_register_bank_tb
  import pll_bank_pkg::*;
;
  localparam logic [23:0] ID_WORD = 24'h3C5A96;  // Arbitrary identity value
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        sclk, sdi, serialEnable, sdo;
  logic        calValid = 1'b0;
  logic [8:0]  calData = 9'h000;
  logic        refBufferEnable = 1'b0;
  logic [9:0]  ctrlWord;
  logic [13:0] refDivider;
  logic [18:0] intDivide;
  logic [23:0] fracDivide;
  logic        refDividerActive, linkClk, linkData, linkEnable, linkBusy;
  int          failures = 0;
  int          total_checks = 0;
  int          cycles = 0;
  int          bitCnt = 0;
  int          riseGap = 0;   // Block cycles since the last link clock rise
  logic [15:0] sentQ[$];      // Words seen on the link
  logic [15:0] shiftW = 16'h0000;
  logic        clkPrev = 1'b0;
  logic        enPrev = 1'b0;
  logic [23:0] model[8];      // Expected register contents
  logic [23:0] rd, d;
  logic [4:0]  a;
  logic [15:0] vw, w2;
  logic [4:0]  cornerA[4] = '{ADDR_REFDIV, ADDR_INT, ADDR_INT, ADDR_FRAC};
  logic [23:0] cornerD[4] = '{24'h003FFF, 24'h07FFFF, 24'h000010, 24'hFFFFFF};

  always #20 ref_clk = ~ref_clk;

  pll_register_bank #(.IDENTITY(ID_WORD)) DUT (
    .ref_clk(ref_clk), .rst_n(rst_n), .sclk(sclk), .sdi(sdi),
    .serialEnable(serialEnable), .sdo(sdo), .calValid(calValid),
    .calData(calData), .refBufferEnable(refBufferEnable), .ctrlWord(ctrlWord),
    .refDivider(refDivider), .intDivide(intDivide), .fracDivide(fracDivide),
    .refDividerActive(refDividerActive), .linkClk(linkClk),
    .linkData(linkData), .linkEnable(linkEnable), .linkBusy(linkBusy));

  host_port_model hostModel (
    .ref_clk(ref_clk), .sclk(sclk), .sdi(sdi), .serialEnable(serialEnable), .sdo(sdo));

  // ****************************************
  // Link monitor and watchdog
  // ****************************************
  // Bits are taken at each link clock rise inside an enable window
  always @(posedge ref_clk) begin
    clkPrev <= linkClk;
    enPrev <= linkEnable;
    if (linkEnable && !enPrev) bitCnt <= 0;
    if (linkEnable && linkClk && !clkPrev) begin
      shiftW <= {shiftW[14:0], linkData};
      bitCnt <= bitCnt + 1;
      riseGap <= 1;
      // Rise to rise spans two link ticks
      if (bitCnt != 0) `CHK("link clock period", 2 * FSM_DIV, riseGap)
    end else begin
      riseGap <= riseGap + 1;
    end
    if (!linkEnable && enPrev) begin
      sentQ.push_back(shiftW);
      `CHK("link bit count", 16, bitCnt)
    end
  end

  // A hang counts as a mismatch and closes the run
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      give_verdict();
    end
  end

  // ****************************************
  // Helpers
  // ****************************************
  // Keep only the bits a location really holds
  function automatic logic [23:0] fit(input logic [4:0] ad, input logic [23:0] v);
    case (ad)
      ADDR_CTRL:   fit = v & 24'h0003FF;
      ADDR_REFDIV: fit = v & 24'h003FFF;
      ADDR_INT:    fit = v & 24'h07FFFF;
      ADDR_FRAC:   fit = v;
      default:     fit = 24'h000000;
    endcase
  endfunction

  task automatic setDefaults();
    model[1] = {14'h0000, CTRL_RESET};
    model[2] = {10'h000, REFDIV_RESET};
    model[3] = {5'h00, INT_RESET};
    model[4] = FRAC_RESET;
  endtask

  task automatic checkOuts();
    `CHK("ctrlWord", model[1][9:0], ctrlWord)
    `CHK("refDivider", model[2][13:0], refDivider)
    `CHK("intDivide", model[3][18:0], intDivide)
    `CHK("fracDivide", model[4], fracDivide)
  endtask

  task automatic wr(input logic [4:0] ad, input logic [23:0] v);
    hostModel.frame(v, ad, CHIP_ADDR, 32, rd);
  endtask

  // First frame picks the location, second frame shifts it out
  task automatic rdReg(input logic [4:0] ad, output logic [23:0] v);
    hostModel.frame({19'h00000, ad}, ADDR_ID, CHIP_ADDR, 32, v);
    hostModel.frame({19'h00000, ad}, ADDR_ID, CHIP_ADDR, 32, v);
  endtask

  task automatic waitLink(input int n);
    for (int i = 0; i < 400 && sentQ.size() < n; i++) @(negedge ref_clk);
  endtask

  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(32'hFC97));
    repeat (20) @(negedge ref_clk);
    rst_n = 1'b1;
    hostModel.waitn(4);
    setDefaults();
    checkOuts();
    `CHK("linkBusy idle", 1'b0, linkBusy)
    rdReg(ADDR_ID, rd);
    `CHK("identity", ID_WORD, rd)
    $display("Test reset and identity done");
    // Boundary values first, then random contents
    for (int n = 0; n < 10; n++) begin
      a = (n < 4) ? cornerA[n] : 5'(1 + $urandom_range(3));
      d = (n < 4) ? cornerD[n] : (24'($urandom()) | 24'h000014);
      wr(a, d);
      model[a[2:0]] = fit(a, d);
      checkOuts();
      rdReg(a, rd);
      `CHK("readback", model[a[2:0]], rd)
    end
    wr(5'h07, 24'($urandom()));
    rdReg(5'h07, rd);
    `CHK("unmapped read", 24'h000000, rd)
    $display("Test register writes done");
    // Wrong chip address and a short frame must change nothing
    hostModel.frame(24'($urandom()), ADDR_INT, 3'h5, 32, rd);
    hostModel.frame(24'($urandom()), ADDR_FRAC, CHIP_ADDR, 31, rd);
    checkOuts();
    refBufferEnable = 1'b1;
    hostModel.waitn(1);
    `CHK("divider active", model[2] != 0, refDividerActive)
    refBufferEnable = 1'b0;
    hostModel.waitn(1);
    `CHK("divider idle", 1'b0, refDividerActive)
    $display("Test refused frames done");
    // Manual reset word keeps switch settings, tune off, address zero
    vw = {8'($urandom()), 1'b0, 4'h0, 3'h0};
    wr(ADDR_VCO, {8'h00, vw});
    waitLink(1);
    `CHK("forwarded word", vw, sentQ[0])
    rdReg(ADDR_VCO, rd);
    `CHK("indirect readback", {8'h00, vw}, rd)
    // Calibration lands while the host word is still shifting out
    sentQ.delete();
    w2 = {9'($urandom()), 4'h0, 3'h0};
    wr(ADDR_VCO, {8'h00, w2});
    `CHK("linkBusy shifting", 1'b1, linkBusy)
    calData = 9'($urandom());
    calValid = 1'b1;
    hostModel.waitn(1);
    calValid = 1'b0;
    waitLink(2);
    `CHK("host word", w2, sentQ[0])
    `CHK("calibration word", {calData, w2[6:0]}, sentQ[1])
    $display("Test indirect link done");
    wr(ADDR_ID, 24'h000020);
    setDefaults();
    checkOuts();
    hostModel.frame(24'h000000, ADDR_ID, CHIP_ADDR, 32, rd);
    `CHK("identity after soft reset", ID_WORD, rd)
    $display("Test soft reset done");
    give_verdict();
  end
endmodule
